/* File: common/sbs_pkg.sv */
// ----------------------------------------------------------------------
// burst sram shared definitions
// ----------------------------------------------------------------------
package sbs_pkg;

    // ------------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W   = 16;      // word address inputs
    localparam int DATA_W   = 32;      // shared data bus width
    localparam int LANES    = 4;       // byte lanes on the data bus
    localparam int LANE_W   = 8;       // bits per byte lane
    localparam int BURST_W  = 2;       // burst counter width
    localparam int DEPTH    = 65536;   // words in the array
    localparam int ARRAY_BITS = DEPTH * DATA_W; // 2,097,152 bits

    // ------------------------------------------------------------------
    // strap defaults, as if the mode pins were left open
    // ------------------------------------------------------------------
    localparam logic OUT_REG_MODE_RST = 1'b1; // pull-up: pipelined
    localparam logic BURST_ORDER_RST  = 1'b1; // pull-up: interleaved
    localparam logic [LANES-1:0] ALL_LANES = 4'hf;
    localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;

    // ------------------------------------------------------------------
    // captured cycle kind, gray along desel -> read -> write
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SBS_DESEL = 2'b00,
        SBS_READ  = 2'b01,
        SBS_WRITE = 2'b11
    } sbs_cyc_t;

    // ------------------------------------------------------------------
    // pin groups
    // ------------------------------------------------------------------
    typedef struct packed {
        logic select_first_n;    // active low chip enable
        logic select_second;     // active high chip enable
        logic select_third_n;    // active low chip enable
    } sbs_sel_t;

    typedef struct packed {
        logic cpu_addr_strobe_n;  // processor address strobe
        logic ctrl_addr_strobe_n; // controller address strobe
        logic burst_advance_n;    // burst advance
    } sbs_strobe_t;

    typedef struct packed {
        logic             global_write_n;      // write all lanes
        logic             byte_write_enable_n; // lane-qualified write
        logic [LANES-1:0] lane_enable_n;       // per-lane write enable
    } sbs_wctl_t;

endpackage : sbs_pkg

/* File: hw/sbs_mem.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// storage array with lane writes and a registered read port
// ----------------------------------------------------------------------
module sbs_mem (
    // clock
    input  wire logic                         clk_i,
    // access port
    input  wire logic [sbs_pkg::ADDR_W-1:0]   addr_i,
    input  wire logic [sbs_pkg::LANES-1:0]    wr_lane_i,
    input  wire logic [sbs_pkg::DATA_W-1:0]   wdata_i,
    output logic      [sbs_pkg::DATA_W-1:0]   rdata_o
);

    // no reset on the array: contents survive everything but power
    logic [sbs_pkg::DATA_W-1:0] mem [sbs_pkg::DEPTH];

    // ------------------------------------------------------------------
    // lane writes and read, read sees the old word on a collision
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        for (int l = 0; l < sbs_pkg::LANES; l++) begin
            if (wr_lane_i[l]) begin
                mem[addr_i][l*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] <=
                    wdata_i[l*sbs_pkg::LANE_W +: sbs_pkg::LANE_W];
            end
        end
        rdata_o <= mem[addr_i];
    end

endmodule : sbs_mem

`default_nettype wire

/* File: hw/sbs_sram.sv */
// How it works
// - inputs sampled on rising clock edge
// - output enable and sleep act asynchronously
// - either address strobe starts burst, loads address
// - counter steps only when advance is low
// - two-bit counter preset from low address
// - order pin low linear, high interleaved
// - new address accepted every cycle
// - mode pin low flow-through, high pipelined
// - deselect turns drivers off one stage early in pipelined mode
// - byte write writes only enabled lanes
// - global write writes all four lanes
// - sleep or stopped clock keeps data
// - open mode pins give interleaved, pipelined, awake
// - selected when first, third low, second high
// - strobes, advance, write controls active low
// - low address bits preset the counter
// - four byte lanes with own enables
// - writes land on the capturing edge from the live decoded controls, not from wr_lane_q
// - drivers stay on until a write is captured, so a write right after a read overlaps the controller
// - array is 65536 words of 32 bits
// - linear adds step, interleaved xors step
// - no lanes enabled means read cycle
// - processor strobe always begins a read when the chip is selected and awake
// - enable high forces drivers off at once
`timescale 1ns/10ps
`default_nettype none

module sbs_sram (
    // clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         arst_n_i,
    // address and controls, synchronous to clk_i
    input  wire logic [sbs_pkg::ADDR_W-1:0]   addr_i,
    input  wire sbs_pkg::sbs_sel_t            sel_i,
    input  wire sbs_pkg::sbs_strobe_t         strobe_i,
    input  wire sbs_pkg::sbs_wctl_t           wctl_i,
    // asynchronous controls
    input  wire logic                         out_enable_n_i,
    input  wire logic                         sleep_input_i,
    // static mode straps
    input  wire logic                         output_reg_mode_pin_i,
    input  wire logic                         burst_order_pin_i,
    // shared data bus, split into three signals
    input  wire logic [sbs_pkg::DATA_W-1:0]   data_i,
    output logic      [sbs_pkg::DATA_W-1:0]   data_o,
    output logic                              data_oe_o
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic                           ft_meta;      // strap sync stage 1
    logic                           pipe_mode;    // 1: pipelined output
    logic                           ord_meta;     // strap sync stage 1
    logic                           interleave;   // 1: interleaved order
    logic [sbs_pkg::ADDR_W-1:0]     addr_q;       // address in use
    logic [sbs_pkg::BURST_W-1:0]    start_q;      // burst start bits
    logic [sbs_pkg::BURST_W-1:0]    step_q;       // beats advanced
    logic                           active_q;     // a burst is open
    sbs_pkg::sbs_cyc_t              cyc_q;        // cycle now captured
    sbs_pkg::sbs_cyc_t              cyc_d1;       // cycle one edge ago
    logic [sbs_pkg::LANES-1:0]      wr_lane_q;    // lanes last written
    logic [sbs_pkg::DATA_W-1:0]     mem_rdata;    // flow-through data
    logic [sbs_pkg::DATA_W-1:0]     pipe_q;       // pipelined data

    // ------------------------------------------------------------------
    // mode straps: static pins, still synchronised before use
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ft_meta   <= sbs_pkg::OUT_REG_MODE_RST;
            pipe_mode <= sbs_pkg::OUT_REG_MODE_RST;
            ord_meta  <= sbs_pkg::BURST_ORDER_RST;
            interleave <= sbs_pkg::BURST_ORDER_RST;
        end else begin
            ft_meta    <= output_reg_mode_pin_i;
            pipe_mode  <= ft_meta;
            ord_meta   <= burst_order_pin_i;
            interleave <= ord_meta;
        end
    end

    // ------------------------------------------------------------------
    // chip select and strobe decode
    // ------------------------------------------------------------------
    // all enables qualify a start; only the first gates the cpu strobe
    wire first_on  = !sel_i.select_first_n;
    wire selected  = first_on && sel_i.select_second
                     && !sel_i.select_third_n;
    wire cpu_stb   = !strobe_i.cpu_addr_strobe_n && first_on;
    wire ctrl_stb  = !strobe_i.ctrl_addr_strobe_n
                     && !cpu_stb;
    // sleep blocks every new cycle without waiting for an edge
    wire awake     = !sleep_input_i;

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    wire byte_wr   = !wctl_i.byte_write_enable_n
                     && !(&wctl_i.lane_enable_n);
    wire glob_wr   = !wctl_i.global_write_n;
    wire want_wr   = glob_wr || byte_wr;
    // global write overrides every lane mask
    wire [sbs_pkg::LANES-1:0] lane_mask =
        glob_wr ? sbs_pkg::ALL_LANES :
        (wctl_i.byte_write_enable_n ? '0 :
         ~wctl_i.lane_enable_n);

    // ------------------------------------------------------------------
    // cycle kind
    // ------------------------------------------------------------------
    // a strobe with the chip unselected is a deselect, except a cpu strobe with the first enable off, which is ignored; without a
    // strobe the open burst continues or suspends
    wire start_any = (cpu_stb || ctrl_stb) && selected && awake;
    wire desel_any = ((cpu_stb || ctrl_stb) && !selected)
                     || !awake;
    wire cont_any  = !cpu_stb && !ctrl_stb && active_q && awake;
    wire step_now  = cont_any && !strobe_i.burst_advance_n;

    sbs_pkg::sbs_cyc_t next_cyc;
    always_comb begin
        next_cyc = sbs_pkg::SBS_DESEL;
        case ({start_any, cont_any})
            2'b10: begin
                // processor strobe ignores the write controls
                next_cyc = (cpu_stb || !want_wr) ? sbs_pkg::SBS_READ
                                                 : sbs_pkg::SBS_WRITE;
            end
            2'b01: begin
                next_cyc = want_wr ? sbs_pkg::SBS_WRITE
                                   : sbs_pkg::SBS_READ;
            end
            default: begin
                next_cyc = sbs_pkg::SBS_DESEL;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // burst address generation
    // ------------------------------------------------------------------
    wire [sbs_pkg::BURST_W-1:0] next_step  = step_q + sbs_pkg::STEP_ONE;
    wire [sbs_pkg::BURST_W-1:0] step_use   = step_now ? next_step : step_q;
    // both orders wrap after four beats by counter width alone
    wire [sbs_pkg::BURST_W-1:0] burst_low  =
        interleave ? (start_q ^ step_use)
                   : (start_q + step_use);
    wire [sbs_pkg::ADDR_W-1:0]  next_addr  =
        start_any ? addr_i :
        {addr_q[sbs_pkg::ADDR_W-1:sbs_pkg::BURST_W], burst_low};
    wire                        is_write   =
        (next_cyc == sbs_pkg::SBS_WRITE);
    wire [sbs_pkg::LANES-1:0]   next_lanes =
        is_write ? (start_any && !ctrl_stb ? '0 : lane_mask)
                 : '0;

    // ------------------------------------------------------------------
    // burst state registers
    // ------------------------------------------------------------------
    // a fresh address may load on any edge, so no idle cycle is spent
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_q   <= '0;
            start_q  <= '0;
            step_q   <= '0;
            active_q <= 1'b0;
        end else if (start_any) begin
            addr_q   <= addr_i;
            start_q  <= addr_i[sbs_pkg::BURST_W-1:0];
            step_q   <= '0;
            active_q <= 1'b1;
        end else if (desel_any) begin
            active_q <= 1'b0;
        end else if (step_now) begin
            addr_q   <= next_addr;
            step_q   <= next_step;
        end
    end

    // ------------------------------------------------------------------
    // cycle pipeline
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cyc_q     <= sbs_pkg::SBS_DESEL;
            cyc_d1    <= sbs_pkg::SBS_DESEL;
            wr_lane_q <= '0;
        end else begin
            cyc_q     <= next_cyc;
            cyc_d1    <= cyc_q;
            wr_lane_q <= next_lanes;
        end
    end

    // ------------------------------------------------------------------
    // array: write lands on the capturing edge, no extra strobe needed
    // ------------------------------------------------------------------
    sbs_mem u_mem (
        .clk_i     (clk_i),
        .addr_i    (next_addr),
        .wr_lane_i (next_lanes),
        .wdata_i   (data_i),
        .rdata_o   (mem_rdata)
    );

    // ------------------------------------------------------------------
    // output data register for pipelined mode
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pipe_q <= '0;
        end else begin
            pipe_q <= mem_rdata;
        end
    end

    // ------------------------------------------------------------------
    // output drivers
    // ------------------------------------------------------------------
    // flow-through drives in the cycle the read is captured; pipelined
    // waits a stage, but a deselect or write captured now already
    // shuts it, which is the one-stage-short deselect path
    wire drv_flow = (cyc_q == sbs_pkg::SBS_READ);
    wire drv_pipe = (cyc_d1 == sbs_pkg::SBS_READ)
                    && (cyc_q == sbs_pkg::SBS_READ);
    wire rd_phase = pipe_mode ? drv_pipe : drv_flow;
    // enable and sleep gate the drivers with no clock in the path
    assign data_oe_o = rd_phase && !out_enable_n_i
                       && !sleep_input_i;
    assign data_o    = pipe_mode ? pipe_q : mem_rdata;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_oe_forces_off:
    assert property (@(posedge clk_i) disable iff (!arst_n_i)
        out_enable_n_i |-> !data_oe_o)
    else $error("drivers on while output enable is high");

    a_sleep_quiet:
    assert property (@(posedge clk_i) disable iff (!arst_n_i)
        sleep_input_i |=> (wr_lane_q == '0) && !data_oe_o)
    else $error("activity while asleep");

    a_write_no_drive:
    assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (cyc_q == sbs_pkg::SBS_WRITE) |-> !data_oe_o)
    else $error("bus driven during a write cycle");

    a_start_loads:
    assert property (@(posedge clk_i) disable iff (!arst_n_i)
        start_any |=> (addr_q == $past(addr_i)) && (step_q == '0)
                      && active_q)
    else $error("burst start did not load the address");

    a_hold_no_advance:
    assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (cont_any && strobe_i.burst_advance_n) |=> $stable(addr_q))
    else $error("address moved without advance");

    a_linear_step:
    assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (step_now && !interleave) |=>
        addr_q[1:0] == 2'(start_q + step_q))
    else $error("linear burst sequence wrong");

    a_inter_step:
    assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (step_now && interleave) |=> addr_q[1:0] == (start_q ^ step_q))
    else $error("interleaved burst sequence wrong");

    a_cpu_reads:
    assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (cpu_stb && selected && awake) |=>
        (cyc_q == sbs_pkg::SBS_READ) && (wr_lane_q == '0))
    else $error("processor strobe began a write");

    a_global_lanes:
    assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (glob_wr && ctrl_stb && selected && awake) |=>
        wr_lane_q == sbs_pkg::ALL_LANES)
    else $error("global write missed a lane");

    a_unselected_off:
    assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ((cpu_stb || ctrl_stb) && !selected) |=>
        (cyc_q == sbs_pkg::SBS_DESEL) ##1 (cyc_d1 == sbs_pkg::SBS_DESEL))
    else $error("unselected strobe began a cycle");

    a_pipe_latency:
    assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (pipe_mode && !out_enable_n_i && !sleep_input_i
         && cyc_q == sbs_pkg::SBS_READ && cyc_d1 != sbs_pkg::SBS_READ)
        |-> !data_oe_o)
    else $error("pipelined read drove one stage early");

    a_desel_fast_off:
    assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (cyc_q == sbs_pkg::SBS_DESEL) |-> !data_oe_o)
    else $error("drivers on after deselect captured");

endmodule : sbs_sram

`default_nettype wire

/* File: testbench/sbs_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// controller model: one registered bus cycle per clock
// ----------------------------------------------------------------------
module sbs_ctrl_model (
    // clock
    input  wire logic                       clk_i,
    // device side of the shared data bus
    input  wire logic [sbs_pkg::DATA_W-1:0] data_o_i,
    input  wire logic                       data_oe_i,
    // controls toward the device
    output var  sbs_pkg::sbs_sel_t          sel_o,
    output var  sbs_pkg::sbs_strobe_t       strobe_o,
    output var  sbs_pkg::sbs_wctl_t         wctl_o,
    output logic [sbs_pkg::ADDR_W-1:0]      addr_o,
    // bus level and contention flag
    output logic [sbs_pkg::DATA_W-1:0]      bus_o,
    output logic                            clash_o
);
    logic                       drv;  // controller owns the bus
    logic [sbs_pkg::DATA_W-1:0] dq;   // value it drives
    logic [sbs_pkg::DATA_W-1:0] last; // last value it drove

    // a released bus has no keeper: show the inverse, not a stale copy
    assign bus_o = drv ? dq : (data_oe_i ? data_o_i : ~last);

    // idle at time zero: unselected, no strobe, no write
    initial begin
        sel_o    = 3'h6;
        strobe_o = 3'h7;
        wctl_o   = 6'h3f;
        addr_o   = 16'h0000;
        dq       = 32'h0;
        last     = 32'h0;
        drv      = 1'b0;
        clash_o  = 1'b0;
    end

    // both parties driving at mid-cycle is a contention
    always @(negedge clk_i) begin
        if (drv && data_oe_i) clash_o <= 1'b1;
    end

    // drive now, just after an edge, hold up to the capturing edge and
    // return on it, so the caller can look at the answer to this beat
    task automatic beat(input logic [2:0] s, input logic [2:0] st,
                        input logic [5:0] w, input logic [15:0] a,
                        input logic [31:0] d, input logic dr);
        sel_o    <= s;
        strobe_o <= st;
        wctl_o   <= w;
        addr_o   <= a;
        dq       <= d;
        drv      <= dr;
        if (dr) last <= d;
        @(posedge clk_i);
    endtask : beat
endmodule : sbs_ctrl_model

`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam logic [2:0] ON = 3'h2;  // chip selected
    logic                 clk_i;
    logic                 arst_n_i;
    logic                 oe_n;        // asynchronous output enable
    logic                 sleep;       // asynchronous sleep
    logic                 out_mode;    // strap: 1 pipelined
    logic                 order;       // strap: 1 interleaved
    logic                 pipe;        // mode the bench expects
    sbs_pkg::sbs_sel_t    sel;
    sbs_pkg::sbs_strobe_t strobe;
    sbs_pkg::sbs_wctl_t   wctl;
    logic [15:0]          addr;
    logic [31:0]          bus;
    logic [31:0]          data_o;
    logic                 data_oe;
    logic                 clash;
    int                   error_cnt = 0;
    int                   samples_checked = 0;

    sbs_sram sbs_sram_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .addr_i(addr), .sel_i(sel), .strobe_i(strobe), .wctl_i(wctl),
        .out_enable_n_i(oe_n), .sleep_input_i(sleep),
        .output_reg_mode_pin_i(out_mode), .burst_order_pin_i(order),
        .data_i(bus), .data_o(data_o), .data_oe_o(data_oe));

    sbs_ctrl_model sbs_ctrl_model_i (.clk_i(clk_i), .data_o_i(data_o),
        .data_oe_i(data_oe), .sel_o(sel), .strobe_o(strobe),
        .wctl_o(wctl), .addr_o(addr), .bus_o(bus), .clash_o(clash));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // sample once the edge's updates have landed
    task automatic look(input logic e_oe, input logic [31:0] exp);
        #2;
        check("drive", {31'h0, e_oe}, {31'h0, data_oe});
        if (e_oe) check("data", exp, data_o);
    endtask : look

    task automatic bt(input logic [2:0] s, input logic [2:0] st,
                      input logic [5:0] w, input logic [15:0] a,
                      input logic [31:0] d, input logic dr);
        sbs_ctrl_model_i.beat(s, st, w, a, d, dr);
    endtask : bt

    task automatic desel();
        bt(3'h6, 3'h5, 6'h3f, 16'h0, 32'h0, 1'b0);
    endtask : desel

    task automatic sus();
        bt(ON, 3'h7, 6'h3f, 16'h0, 32'h0, 1'b0);
    endtask : sus

    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic [5:0] w);
        bt(ON, 3'h5, w, a, d, 1'b1);
    endtask : wr

    // straps settle through a two-stage synchroniser, held at defaults in reset; a mode change still resets
    task automatic rst(input logic f, input logic l);
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        out_mode <= f;
        order    <= l;
        pipe = f;
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask : rst

    // single read from a deselected state, then deselect
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        bt(ON, 3'h5, 6'h3f, a, 32'h0, 1'b0);
        if (pipe) begin
            look(1'b0, 32'h0);
            sus();
        end
        look(1'b1, exp);
        desel();
        look(1'b0, 32'h0);
    endtask : rd_chk

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_global();
        desel();
        wr(16'h0010, 32'h01020304, 6'h1f);
        wr(16'h0011, 32'h05060708, 6'h0a);
        desel();
        rd_chk(16'h0010, 32'h01020304);
        rd_chk(16'h0011, 32'h05060708);
    endtask : t_global

    task automatic t_lanes();
        wr(16'h0020, 32'h11223344, 6'h1f);
        wr(16'h0020, 32'haabbccdd, 6'h2a);
        bt(3'h0, 3'h5, 6'h1f, 16'h0020, 32'h0, 1'b1);
        bt(3'h3, 3'h5, 6'h1f, 16'h0020, 32'h0, 1'b1);
        wr(16'h0020, 32'hffffffff, 6'h2f);
        bt(ON, 3'h3, 6'h00, 16'h0020, 32'h0, 1'b0);
        desel();
        rd_chk(16'h0020, 32'h11bb33dd);
    endtask : t_lanes

    // burst write from word 0, burst read from 1 across the wrap
    task automatic t_burst(input logic l);
        int         i;
        logic [1:0] j;
        rst(1'b1, l);
        desel();
        wr(16'h0040, 32'hbeef0000, 6'h1f);
        for (i = 1; i < 4; i++) begin
            bt(ON, 3'h6, 6'h1f, 16'h0, 32'hbeef0000 | 32'(i), 1'b1);
        end
        desel();
        bt(ON, 3'h5, 6'h3f, 16'h0041, 32'h0, 1'b0);
        for (i = 0; i < 5; i++) begin
            if (i < 4) bt(ON, 3'h6, 6'h3f, 16'h0, 32'h0, 1'b0);
            else sus();
            j = l ? (2'h1 ^ 2'(i)) : (2'h1 + 2'(i));
            look(1'b1, 32'hbeef0000 | 32'(j));
        end
        desel();
        look(1'b0, 32'h0);
    endtask : t_burst

    task automatic t_async();
        rst(1'b0, 1'b1);
        bt(ON, 3'h5, 6'h3f, 16'h0020, 32'h0, 1'b0);
        look(1'b1, 32'h11bb33dd);
        sus();
        oe_n <= 1'b1;
        look(1'b0, 32'h0);
        sus();
        oe_n <= 1'b0;
        look(1'b1, 32'h11bb33dd);
        sus();
        sleep <= 1'b1;
        look(1'b0, 32'h0);
        desel();
        sleep <= 1'b0;
        look(1'b0, 32'h0);
        rd_chk(16'h0020, 32'h11bb33dd);
    endtask : t_async

    task automatic final_report();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // the run needs about 110 cycles; 3000 cycles, over 25 times that, means a hang
    initial begin
        #(3000 * 20);
        error_cnt++;
        final_report();
    end

    initial begin
        arst_n_i = 1'b0;
        oe_n     = 1'b0;
        sleep    = 1'b0;
        out_mode = 1'b1;
        order    = 1'b1;
        pipe     = 1'b1;
        rst(1'b1, 1'b1);
        t_global();
        t_lanes();
        t_burst(1'b1);
        t_burst(1'b0);
        t_async();
        check("clash", 32'h0, {31'h0, clash});
        final_report();
    end
endmodule : testbench

`default_nettype wire
